// File: logic/gauge_defs.vh
`ifndef GAUGE_DEFS_VH
`define GAUGE_DEFS_VH

// ----------------------------------------
// Load model kinds and choices
// ----------------------------------------
`define MODEL_CURRENT 1'b0
`define MODEL_POWER 1'b1
`define CHOICE_PREV_CYCLE 3'h0
`define CHOICE_THIS_CYCLE 3'h1
`define CHOICE_AVG_IV 3'h2
`define CHOICE_FILT_IV 3'h3
`define CHOICE_DESIGN_DIV 3'h4
`define CHOICE_HYPO_RATE 3'h5
`define CHOICE_USER_RATE 3'h6
`define DESIGN_DIVISOR 16'h0005
`define RATE_UNIT_MW 16'h000A
`define PCT_DIVISOR 32'h0000_0064

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ 32'h0131_2D00
`define TICK_DIV 32'h0131_2D00
`define FILT_TAU_S 16'h000E
`define OCV_WAIT_S 16'h0168
`define SLOPE_LIMIT_UV 16'h0004

// ----------------------------------------
// Status byte
// ----------------------------------------
`define LEARN_BIT 0
`define LEARN_RESET 8'h00

`endif

// File: logic/sec_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "gauge_defs.vh"

// Counts seconds while run is high, restarts on clr
module sec_timer (
   // Clock and reset
   input wire mclk,
   input wire rst_b,
   // Control
   input wire tick,
   input wire run,
   input wire clr,
   // Count
   output reg [15:0] secs_r
);
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         secs_r <= 16'h0000;
      end else if (clr || !run) begin
         secs_r <= 16'h0000;
      end else if (tick && secs_r != 16'hFFFF) begin
         secs_r <= secs_r + 16'h0001;
      end
   end
endmodule // sec_timer

`default_nettype wire

// File: logic/gauge_load_model_relax_control.v
// Behaviour
// RQ1: Kind picks constant current or power model
// RQ2: Power choices 0,1: previous or present average
// RQ3: Choice 2 avg I*V; 3 filtered I*V
// RQ4: Choice 4 uses design energy over five
// RQ5: Choices 5,6 rate values in 10 mW
// RQ6: Reserve held back, no-load compensated
// RQ7: Discharge only above discharge threshold
// RQ8: Charge only above charge threshold
// RQ9: Relax after quiet for relax time
// RQ10: OCV readings after six relaxed minutes
// RQ11: Capacity update also needs slope below four
// RQ12: Leave relax after quit relax time
// RQ13: Learning status bit 0 set on learning
// RQ14: Average discharge current per cycle, keep previous
// RQ15: Power I*V averaged per cycle, keep previous
// RQ16: Record largest spike voltage difference
// RQ17: Clamp each resistance step to limit
// RQ18: Clamp cumulative resistance scale per cycle
// RQ19: No back scaling beyond grid limit
// RQ20: Clamp voltage delta between min and max
// RQ21: Clamp capacity step to design percentage
// RQ22: Clamp voltage-gap step to limit
// RQ23: Relax timers restart on comparison change
`timescale 1ns/1ps
`default_nettype none
`include "gauge_defs.vh"

module gauge_load_model_relax_control #(
   // Second tick length in clock cycles
   parameter [31:0] TICK_CYC = `TICK_DIV
) (
   // Clock and reset
   input wire mclk,
   input wire rst_b,
   // Measurements (inst_current per sample_stb, spike_voltage per spike_stb, others read every clock)
   input wire sample_stb,
   input wire signed [15:0] inst_current,
   input wire signed [15:0] avg_current,
   input wire [15:0] voltage,
   input wire signed [15:0] volt_slope_uv,
   input wire spike_stb,
   input wire [15:0] spike_voltage,
   // Configuration
   input wire load_model_kind,
   input wire [2:0] load_model_choice,
   input wire [15:0] design_capacity,
   input wire [15:0] design_energy,
   input wire signed [15:0] hypothetical_rate,
   input wire [15:0] user_rate,
   input wire [15:0] reserve_charge,
   input wire [15:0] reserve_energy,
   input wire [15:0] dsg_threshold,
   input wire [15:0] chg_threshold,
   input wire [15:0] relax_current_limit,
   input wire [15:0] dsg_relax_secs,
   input wire [15:0] chg_relax_secs,
   input wire [15:0] quit_relax_secs,
   // Resistance update
   input wire res_upd_stb,
   input wire [15:0] res_old,
   input wire [15:0] res_new,
   input wire [15:0] res_cycle_base,
   input wire [3:0] res_grid_index,
   input wire [15:0] resistance_step_limit,
   input wire [7:0] resistance_scale_floor,
   input wire [7:0] resistance_scale_ceiling,
   input wire [3:0] backscale_grid_limit,
   // Capacity and voltage-gap update
   input wire cap_upd_stb,
   input wire [15:0] cap_new,
   input wire [7:0] cap_step_pct,
   input wire gap_upd_stb,
   input wire [15:0] gap_new,
   input wire [15:0] gap_min,
   input wire [15:0] gap_max,
   input wire [15:0] voltage_gap_step_limit,
   // Load model result
   output reg [31:0] load_rate_r,
   output reg [15:0] reserve_out_r,
   output reg [15:0] reserve_nl_r,
   // Direction and relaxation
   output reg discharging_r,
   output reg charging_r,
   output reg relaxed_r,
   output reg ocv_take_r,
   output reg cap_upd_ok_r,
   // Logs
   output reg [15:0] avg_i_last_r,
   output reg [31:0] avg_p_last_r,
   output reg [15:0] spike_gap_max_r,
   output reg [7:0] learn_status_r,
   // Clamped results
   output reg [15:0] res_out_r,
   output reg res_backscale_ok_r,
   output reg [15:0] cap_r,
   output reg [15:0] gap_r
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function [15:0] mag;
      input signed [15:0] v;
      begin
         mag = v[15] ? (~v + 16'h0001) : v;
      end
   endfunction

   function [15:0] step_clamp;
      input [15:0] old_v;
      input [15:0] new_v;
      input [15:0] lim;
      begin
         if (new_v > old_v && (new_v - old_v) > lim) begin
            step_clamp = old_v + lim;
         end else if (new_v < old_v && (old_v - new_v) > lim) begin
            step_clamp = old_v - lim;
         end else begin
            step_clamp = new_v;
         end
      end
   endfunction

   // ----------------------------------------
   // Second tick
   // ----------------------------------------
   reg [31:0] div_r;
   wire tick = (div_r == TICK_CYC - 32'h0000_0001);
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         div_r <= 32'h0000_0000;
      end else begin
         div_r <= tick ? 32'h0000_0000 : div_r + 32'h0000_0001;
      end
   end

   // ----------------------------------------
   // Direction
   // ----------------------------------------
   wire [15:0] i_mag = mag(inst_current);
   wire [15:0] a_mag = mag(avg_current);
   wire dsg_now = inst_current[15] && (i_mag > dsg_threshold); // [RQ7]
   wire chg_now = !inst_current[15] && (i_mag > chg_threshold); // [RQ8]
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         discharging_r <= 1'b0;
         charging_r <= 1'b0;
      end else if (sample_stb) begin
         discharging_r <= dsg_now;
         charging_r <= chg_now;
      end
   end

   // ----------------------------------------
   // Relaxation
   // ----------------------------------------
   wire quiet = (a_mag < relax_current_limit);
   reg quiet_r;
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         quiet_r <= 1'b0;
      end else begin
         quiet_r <= quiet;
      end
   end
   wire cmp_change = (quiet != quiet_r); // [RQ23]
   wire [15:0] quiet_secs;
   wire [15:0] busy_secs;
   wire [15:0] relax_secs;
   sec_timer u_quiet (.mclk(mclk), .rst_b(rst_b), .tick(tick), .run(quiet),
      .clr(cmp_change), .secs_r(quiet_secs)); // [RQ23]
   sec_timer u_busy (.mclk(mclk), .rst_b(rst_b), .tick(tick), .run(!quiet),
      .clr(cmp_change), .secs_r(busy_secs)); // [RQ23]
   sec_timer u_relax (.mclk(mclk), .rst_b(rst_b), .tick(tick), .run(relaxed_r),
      .clr(1'b0), .secs_r(relax_secs));
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         relaxed_r <= 1'b0;
      end else if (!relaxed_r) begin
         if (quiet && (quiet_secs >= dsg_relax_secs || quiet_secs >= chg_relax_secs)) begin
            relaxed_r <= 1'b1; // [RQ9]
         end
      end else if (!quiet && busy_secs >= quit_relax_secs) begin
         relaxed_r <= 1'b0; // [RQ12]
      end
   end
   wire ocv_ok = relaxed_r && (relax_secs >= `OCV_WAIT_S); // [RQ10]
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ocv_take_r <= 1'b0;
         cap_upd_ok_r <= 1'b0;
      end else begin
         ocv_take_r <= ocv_ok;
         cap_upd_ok_r <= ocv_ok && (volt_slope_uv < $signed(`SLOPE_LIMIT_UV)) &&
            (volt_slope_uv > -$signed(`SLOPE_LIMIT_UV)); // [RQ11]
      end
   end

   // ----------------------------------------
   // Discharge cycle averages
   // ----------------------------------------
   wire [31:0] p_inst = i_mag * voltage; // [RQ15]
   reg [47:0] i_sum_r;
   reg [63:0] p_sum_r;
   reg [31:0] n_r;
   reg in_cycle_r;
   wire [31:0] n_div = (n_r == 32'h0000_0000) ? 32'h0000_0001 : n_r;
   wire [47:0] i_quot = i_sum_r / n_div;
   wire [63:0] p_quot = p_sum_r / n_div;
   wire [15:0] i_now_avg = i_quot[15:0];
   wire [31:0] p_now_avg = p_quot[31:0];
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         i_sum_r <= 48'h0000_0000_0000;
         p_sum_r <= 64'h0000_0000_0000_0000;
         n_r <= 32'h0000_0000;
         in_cycle_r <= 1'b0;
         avg_i_last_r <= 16'h0000;
         avg_p_last_r <= 32'h0000_0000;
      end else if (sample_stb) begin
         if (dsg_now) begin
            in_cycle_r <= 1'b1;
            i_sum_r <= i_sum_r + {32'h0000_0000, i_mag}; // [RQ14]
            p_sum_r <= p_sum_r + {32'h0000_0000, p_inst}; // [RQ15]
            n_r <= n_r + 32'h0000_0001;
         end else if (in_cycle_r) begin
            in_cycle_r <= 1'b0;
            avg_i_last_r <= i_now_avg; // [RQ14]
            avg_p_last_r <= p_now_avg; // [RQ15]
            i_sum_r <= 48'h0000_0000_0000;
            p_sum_r <= 64'h0000_0000_0000_0000;
            n_r <= 32'h0000_0000;
         end
      end
   end

   // ----------------------------------------
   // Filtered current, first order, tau in seconds
   // ----------------------------------------
   reg [15:0] filt_r;
   wire [15:0] filt_step = (a_mag > filt_r) ? (a_mag - filt_r) / `FILT_TAU_S :
      (filt_r - a_mag) / `FILT_TAU_S;
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         filt_r <= 16'h0000;
      end else if (tick) begin
         filt_r <= (a_mag > filt_r) ? filt_r + filt_step : filt_r - filt_step; // [RQ3]
      end
   end

   // ----------------------------------------
   // Load model
   // ----------------------------------------
   reg [31:0] rate_nxt;
   always @* begin
      rate_nxt = 32'h0000_0000;
      if (load_model_kind == `MODEL_POWER) begin // [RQ1]
         case (load_model_choice)
            `CHOICE_PREV_CYCLE: rate_nxt = avg_p_last_r; // [RQ2]
            `CHOICE_THIS_CYCLE: rate_nxt = p_now_avg; // [RQ2]
            `CHOICE_AVG_IV: rate_nxt = a_mag * voltage; // [RQ3]
            `CHOICE_FILT_IV: rate_nxt = filt_r * voltage; // [RQ3]
            `CHOICE_DESIGN_DIV: rate_nxt = {16'h0000, design_energy / `DESIGN_DIVISOR}; // [RQ4]
            `CHOICE_HYPO_RATE: rate_nxt = mag(hypothetical_rate) * `RATE_UNIT_MW; // [RQ5]
            `CHOICE_USER_RATE: rate_nxt = user_rate * `RATE_UNIT_MW; // [RQ5]
            default: rate_nxt = 32'h0000_0000;
         endcase
      end else begin
         case (load_model_choice)
            `CHOICE_PREV_CYCLE: rate_nxt = {16'h0000, avg_i_last_r};
            `CHOICE_THIS_CYCLE: rate_nxt = {16'h0000, i_now_avg};
            `CHOICE_AVG_IV: rate_nxt = {16'h0000, a_mag};
            `CHOICE_FILT_IV: rate_nxt = {16'h0000, filt_r};
            `CHOICE_DESIGN_DIV: rate_nxt = {16'h0000, design_capacity / `DESIGN_DIVISOR};
            `CHOICE_HYPO_RATE: rate_nxt = {16'h0000, mag(hypothetical_rate)};
            `CHOICE_USER_RATE: rate_nxt = {16'h0000, user_rate};
            default: rate_nxt = 32'h0000_0000;
         endcase
      end
   end
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         load_rate_r <= 32'h0000_0000;
         reserve_out_r <= 16'h0000;
         reserve_nl_r <= 16'h0000;
      end else begin
         load_rate_r <= rate_nxt;
         // Reserve kept in the unit of the active model
         reserve_out_r <= load_model_kind ? reserve_energy : reserve_charge; // [RQ6]
         // No-load compensation: reserve used as is, no rate derating
         reserve_nl_r <= load_model_kind ? reserve_energy : reserve_charge; // [RQ6]
      end
   end

   // ----------------------------------------
   // Spike gap and learning status
   // ----------------------------------------
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         spike_gap_max_r <= 16'h0000;
         learn_status_r <= `LEARN_RESET;
      end else begin
         if (spike_stb && voltage > spike_voltage &&
             (voltage - spike_voltage) > spike_gap_max_r) begin
            spike_gap_max_r <= voltage - spike_voltage; // [RQ16]
         end
         if (cap_upd_stb && cap_upd_ok_r) begin
            learn_status_r[`LEARN_BIT] <= 1'b1; // [RQ13]
         end
      end
   end

   // ----------------------------------------
   // Resistance filtering
   // ----------------------------------------
   wire [15:0] res_step = step_clamp(res_old, res_new, resistance_step_limit); // [RQ17]
   wire [23:0] res_lo = (res_cycle_base * resistance_scale_floor) >> 4;
   wire [23:0] res_hi = (res_cycle_base * resistance_scale_ceiling) >> 4;
   reg [15:0] res_nxt;
   always @* begin
      res_nxt = res_step;
      if ({8'h00, res_step} < res_lo) begin
         res_nxt = res_lo[15:0]; // [RQ18]
      end else if ({8'h00, res_step} > res_hi) begin
         res_nxt = res_hi[15:0]; // [RQ18]
      end
   end
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         res_out_r <= 16'h0000;
         res_backscale_ok_r <= 1'b0;
      end else if (res_upd_stb) begin
         res_out_r <= res_nxt;
         res_backscale_ok_r <= (res_grid_index <= backscale_grid_limit); // [RQ19]
      end
   end

   // ----------------------------------------
   // Capacity and voltage-gap updates
   // ----------------------------------------
   wire [31:0] cap_lim32 = (design_capacity * cap_step_pct) / `PCT_DIVISOR;
   wire [15:0] cap_lim = (cap_lim32[31:16] != 16'h0000) ? 16'hFFFF : cap_lim32[15:0];
   wire [15:0] gap_step = step_clamp(gap_r, gap_new, voltage_gap_step_limit); // [RQ22]
   reg [15:0] gap_nxt;
   always @* begin
      gap_nxt = gap_step;
      if (gap_step < gap_min) begin
         gap_nxt = gap_min; // [RQ20]
      end else if (gap_step > gap_max) begin
         gap_nxt = gap_max; // [RQ20]
      end
   end
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cap_r <= 16'h0000;
         gap_r <= 16'h0000;
      end else begin
         if (cap_upd_stb && cap_upd_ok_r) begin
            cap_r <= step_clamp(cap_r, cap_new, cap_lim); // [RQ21]
         end
         if (gap_upd_stb) begin
            gap_r <= gap_nxt;
         end
      end
   end
endmodule // gauge_load_model_relax_control

`default_nettype wire

// File: testbench/gauge_load_model_relax_control_properties.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Port checks
// ----------------------------------------
module gauge_load_model_relax_control_properties (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Stimulus
   input wire logic sample_stb,
   input wire logic signed [15:0] inst_current,
   input wire logic [15:0] dsg_threshold,
   input wire logic [15:0] chg_threshold,
   input wire logic load_model_kind,
   input wire logic [15:0] reserve_charge,
   input wire logic res_upd_stb,
   input wire logic [15:0] res_old,
   input wire logic [15:0] res_cycle_base,
   input wire logic [3:0] res_grid_index,
   input wire logic [15:0] resistance_step_limit,
   input wire logic [7:0] resistance_scale_floor,
   input wire logic [7:0] resistance_scale_ceiling,
   input wire logic [3:0] backscale_grid_limit,
   input wire logic cap_upd_stb,
   input wire logic gap_upd_stb,
   input wire logic [15:0] gap_new,
   input wire logic [15:0] gap_min,
   input wire logic [15:0] gap_max,
   input wire logic [15:0] voltage_gap_step_limit,
   // Results
   input wire logic discharging_r,
   input wire logic charging_r,
   input wire logic relaxed_r,
   input wire logic ocv_take_r,
   input wire logic cap_upd_ok_r,
   input wire logic [15:0] reserve_out_r,
   input wire logic [15:0] spike_gap_max_r,
   input wire logic [7:0] learn_status_r,
   input wire logic [15:0] res_out_r,
   input wire logic res_backscale_ok_r,
   input wire logic [15:0] cap_r,
   input wire logic [15:0] gap_r
);
   wire logic [15:0] i_mag = inst_current[15] ? 16'(-inst_current) : inst_current;
   function automatic logic near(input logic [15:0] a, b, lim);
      return ({1'b0, a} <= {1'b0, b} + lim) && ({1'b0, b} <= {1'b0, a} + lim);
   endfunction
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   sequence s_dsg_take;
      sample_stb && inst_current[15] && i_mag > dsg_threshold;
   endsequence
   sequence s_chg_take;
      sample_stb && !inst_current[15] && i_mag > chg_threshold;
   endsequence
   sequence s_res_centered;
      res_upd_stb && res_old == res_cycle_base && resistance_scale_floor <= 8'h10
         && resistance_scale_ceiling >= 8'h10;
   endsequence
   sequence s_gap_inside;
      gap_upd_stb && gap_new >= gap_min && gap_new <= gap_max && gap_r >= gap_min
         && gap_r <= gap_max;
   endsequence
   a_dsg_detect: assert property (s_dsg_take |=> discharging_r)
      else $error("discharge not flagged");
   a_dsg_quiet: assert property (sample_stb && !inst_current[15] |=> !discharging_r)
      else $error("discharge flagged on positive current");
   a_chg_detect: assert property (s_chg_take |=> charging_r)
      else $error("charge not flagged");
   a_ocv_relaxed: assert property (ocv_take_r |-> $past(relaxed_r))
      else $error("open circuit reading outside relaxation");
   a_cap_gate: assert property (cap_upd_ok_r |-> $past(relaxed_r))
      else $error("capacity update allowed outside relaxation");
   a_cap_refused: assert property (cap_upd_stb && !cap_upd_ok_r |=> $stable(cap_r))
      else $error("refused capacity update changed value");
   a_learn_reserved: assert property (learn_status_r[7:1] == 7'h00)
      else $error("reserved status bits set");
   a_spike_hold: assert property (spike_gap_max_r >= $past(spike_gap_max_r))
      else $error("spike gap maximum decreased");
   a_res_step: assert property (s_res_centered |=>
      near(res_out_r, $past(res_old), $past(resistance_step_limit)))
      else $error("resistance step too large");
   a_backscale_limit: assert property (res_upd_stb &&
      res_grid_index > backscale_grid_limit |=> !res_backscale_ok_r)
      else $error("back scaling beyond grid limit");
   a_gap_step: assert property (s_gap_inside |=>
      near(gap_r, $past(gap_r), $past(voltage_gap_step_limit)))
      else $error("voltage gap step too large");
   a_reserve_follow: assert property ((!load_model_kind && $stable(load_model_kind)
      && $stable(reserve_charge)) [*2] |-> reserve_out_r == reserve_charge)
      else $error("reserve does not follow setting");
endmodule // gauge_load_model_relax_control_properties

bind gauge_load_model_relax_control gauge_load_model_relax_control_properties i_props (
   .mclk, .rst_b, .sample_stb, .inst_current, .dsg_threshold, .chg_threshold,
   .load_model_kind, .reserve_charge, .res_upd_stb, .res_old, .res_cycle_base,
   .res_grid_index, .resistance_step_limit, .resistance_scale_floor,
   .resistance_scale_ceiling, .backscale_grid_limit, .cap_upd_stb, .gap_upd_stb, .gap_new,
   .gap_min, .gap_max, .voltage_gap_step_limit, .discharging_r, .charging_r, .relaxed_r,
   .ocv_take_r, .cap_upd_ok_r, .reserve_out_r, .spike_gap_max_r, .learn_status_r,
   .res_out_r, .res_backscale_ok_r, .cap_r, .gap_r);

`default_nettype wire

// File: testbench/gauge_load_model_relax_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
   begin \
      compares++; \
      if ((got) !== (exp)) begin \
         miscompares++; \
         $display("MISMATCH %0t got %h exp %h", $time, got, exp); \
      end \
   end

module gauge_load_model_relax_control_tb_top;
   logic mclk, rst_b, sample_stb, spike_stb, load_model_kind, res_upd_stb, cap_upd_stb;
   logic gap_upd_stb, discharging_r, charging_r, relaxed_r, ocv_take_r, cap_upd_ok_r;
   logic res_backscale_ok_r;
   logic signed [15:0] inst_current, avg_current, volt_slope_uv, hypothetical_rate;
   logic [15:0] voltage, spike_voltage, design_capacity, design_energy, user_rate;
   logic [15:0] reserve_charge, reserve_energy, dsg_threshold, chg_threshold, quit_relax_secs;
   logic [15:0] relax_current_limit, dsg_relax_secs, chg_relax_secs, res_old, res_new;
   logic [15:0] res_cycle_base, resistance_step_limit, cap_new, gap_new, gap_min, gap_max;
   logic [15:0] voltage_gap_step_limit, reserve_out_r, reserve_nl_r, avg_i_last_r, cap_r;
   logic [15:0] spike_gap_max_r, res_out_r, gap_r;
   logic [31:0] load_rate_r, avg_p_last_r;
   logic [2:0] load_model_choice;
   logic [3:0] res_grid_index, backscale_grid_limit;
   logic [7:0] resistance_scale_floor, resistance_scale_ceiling, cap_step_pct, learn_status_r;
   int compares = 0;
   int miscompares = 0;
   int cycles = 0;

   gauge_load_model_relax_control #(.TICK_CYC(32'h0000_000A))
      i_gauge_load_model_relax_control (.mclk, .rst_b,
      .sample_stb, .inst_current, .avg_current, .voltage, .volt_slope_uv, .spike_stb,
      .spike_voltage, .load_model_kind, .load_model_choice, .design_capacity,
      .design_energy, .hypothetical_rate, .user_rate, .reserve_charge, .reserve_energy,
      .dsg_threshold, .chg_threshold, .relax_current_limit, .dsg_relax_secs,
      .chg_relax_secs, .quit_relax_secs, .res_upd_stb, .res_old, .res_new, .res_cycle_base,
      .res_grid_index, .resistance_step_limit, .resistance_scale_floor,
      .resistance_scale_ceiling, .backscale_grid_limit, .cap_upd_stb, .cap_new,
      .cap_step_pct, .gap_upd_stb, .gap_new, .gap_min, .gap_max, .voltage_gap_step_limit,
      .load_rate_r, .reserve_out_r, .reserve_nl_r, .discharging_r, .charging_r, .relaxed_r,
      .ocv_take_r, .cap_upd_ok_r, .avg_i_last_r, .avg_p_last_r, .spike_gap_max_r,
      .learn_status_r, .res_out_r, .res_backscale_ok_r, .cap_r, .gap_r);

   // ----------------------------------------
   // Clock, timeout and helpers
   // ----------------------------------------
   always #25 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 6000) begin
         miscompares++;
         test_done();
      end
   end
   task cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic pls(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
      cyc(1);
   endtask
   task smp(input logic [15:0] i);
      inst_current = i;
      pls(sample_stb);
   endtask
   function automatic logic [31:0] abs32(input logic [31:0] v);
      return v[31] ? -v : v;
   endfunction
   task lm(input logic k, input logic [2:0] c, input logic [31:0] e);
      load_model_kind = k;
      load_model_choice = c;
      cyc(3);
      `CHK(abs32(load_rate_r), e);
   endtask
   task rs(input logic [15:0] nw, st, input logic [7:0] fl, ce, input logic [3:0] ix,
      input logic [15:0] e, input logic ok);
      res_new = nw;
      resistance_step_limit = st;
      resistance_scale_floor = fl;
      resistance_scale_ceiling = ce;
      res_grid_index = ix;
      pls(res_upd_stb);
      `CHK(res_out_r, e);
      `CHK(res_backscale_ok_r, ok);
   endtask
   task gp(input logic [15:0] nw, st, mn, mx, e);
      gap_new = nw;
      voltage_gap_step_limit = st;
      gap_min = mn;
      gap_max = mx;
      pls(gap_upd_stb);
      `CHK(gap_r, e);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_load;
      hypothetical_rate = 16'h0019;
      user_rate = 16'h0028;
      design_energy = 16'h03E8;
      design_capacity = 16'h07D0;
      reserve_charge = 16'h0064;
      reserve_energy = 16'h00C8;
      avg_current = 16'hFF9C;
      voltage = 16'h000A;
      lm(1'b1, 3'h4, 32'h0000_00C8);
      `CHK(reserve_out_r, 16'h00C8);
      `CHK(reserve_nl_r, 16'h00C8);
      lm(1'b1, 3'h5, 32'h0000_00FA);
      lm(1'b1, 3'h6, 32'h0000_0190);
      lm(1'b1, 3'h2, 32'h0000_03E8);
      lm(1'b0, 3'h4, 32'h0000_0190);
      `CHK(reserve_out_r, 16'h0064);
      lm(1'b0, 3'h6, 32'h0000_0028);
   endtask
   task t_dir;
      dsg_threshold = 16'h0190;
      chg_threshold = 16'h012C;
      smp(16'hFE6F);
      `CHK(discharging_r, 1'b1);
      smp(16'hFE70);
      `CHK(discharging_r, 1'b0);
      smp(16'h012D);
      `CHK(charging_r, 1'b1);
      smp(16'h012C);
      `CHK(charging_r, 1'b0);
   endtask
   task t_avg;
      dsg_threshold = 16'h0064;
      voltage = 16'h0E74;
      smp(16'hFDA8);
      smp(16'hFE70);
      lm(1'b1, 3'h1, 32'h001C_3A90);
      lm(1'b0, 3'h1, 32'h0000_01F4);
      smp(16'h0000);
      `CHK(abs32({{16{avg_i_last_r[15]}}, avg_i_last_r}), 32'h0000_01F4);
      `CHK(abs32(avg_p_last_r), 32'h001C_3A90);
      lm(1'b1, 3'h0, 32'h001C_3A90);
      lm(1'b0, 3'h0, 32'h0000_01F4);
      lm(1'b0, 3'h2, 32'h0000_0064);
      lm(1'b0, 3'h5, 32'h0000_0019);
   endtask
   task t_relax;
      relax_current_limit = 16'h0032;
      avg_current = 16'h0005;
      dsg_relax_secs = 16'h0014;
      chg_relax_secs = 16'h0028;
      quit_relax_secs = 16'h0003;
      volt_slope_uv = 16'h0001;
      spike_voltage = 16'h0DAC;
      pls(spike_stb);
      `CHK(spike_gap_max_r, 16'h00C8);
      cyc(100);
      `CHK(relaxed_r, 1'b0);
      `CHK(ocv_take_r, 1'b0);
      cap_new = 16'h1234;
      cap_step_pct = 8'h0A;
      pls(cap_upd_stb);
      `CHK(cap_r, 16'h0000);
      `CHK(learn_status_r, 8'h00);
      `CHK(cap_upd_ok_r, 1'b0);
      cyc(120);
      `CHK(relaxed_r, 1'b1);
      `CHK(ocv_take_r, 1'b0);
      cyc(3620);
      `CHK(ocv_take_r, 1'b1);
      `CHK(cap_upd_ok_r, 1'b1);
      volt_slope_uv = 16'h0004;
      cyc(2);
      `CHK(cap_upd_ok_r, 1'b0);
      volt_slope_uv = 16'hFFFD;
      cyc(2);
      pls(cap_upd_stb);
      `CHK(cap_r, 16'h00C8);
      `CHK(learn_status_r, 8'h01);
      avg_current = 16'hFF9C;
      cyc(12);
      `CHK(relaxed_r, 1'b1);
      cyc(40);
      `CHK(relaxed_r, 1'b0);
      `CHK(ocv_take_r, 1'b0);
   endtask

   task test_done;
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      {mclk, rst_b, sample_stb, spike_stb, load_model_kind, res_upd_stb, cap_upd_stb,
         gap_upd_stb, inst_current, avg_current, volt_slope_uv, hypothetical_rate, voltage,
         spike_voltage, design_capacity, design_energy, user_rate, reserve_charge,
         reserve_energy, dsg_threshold, chg_threshold, quit_relax_secs, relax_current_limit,
         dsg_relax_secs, chg_relax_secs, res_old, res_new, res_cycle_base,
         resistance_step_limit, cap_new, gap_new, gap_min, gap_max, voltage_gap_step_limit,
         load_model_choice, res_grid_index, backscale_grid_limit, resistance_scale_floor,
         resistance_scale_ceiling, cap_step_pct} = '0;
      cyc(3);
      rst_b = 1'b1;
      cyc(1);
      t_load();
      t_dir();
      t_avg();
      res_old = 16'h0064;
      res_cycle_base = 16'h0064;
      backscale_grid_limit = 4'h5;
      rs(16'h00C8, 16'h0014, 8'h08, 8'h20, 4'h2, 16'h0078, 1'b1);
      rs(16'h0190, 16'h03E8, 8'h08, 8'h18, 4'h9, 16'h0096, 1'b0);
      rs(16'h000A, 16'h03E8, 8'h0C, 8'h20, 4'h5, 16'h004B, 1'b1);
      gp(16'h0064, 16'h001E, 16'h0000, 16'h03E8, 16'h001E);
      gp(16'h0064, 16'h001E, 16'h0000, 16'h03E8, 16'h003C);
      gp(16'h07D0, 16'h03E8, 16'h0000, 16'h01F4, 16'h01F4);
      gp(16'h0000, 16'h03E8, 16'h0258, 16'h03E8, 16'h0258);
      t_relax();
      test_done();
   end
endmodule // gauge_load_model_relax_control_tb_top

`default_nettype wire
